// file: bel_bank.sv
`timescale 1ns/1ns
// Backplane bus error log register bank, local processor side
module bel_bank
	import bel_pkg::*;
#(
	parameter int GRANT_CYC = BEL_GRANT_CYC
) (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        dc_power_good,
	input  wire logic        backplane_halt_line,
	input  wire logic        halt_line_enable,
	input  wire logic        pwr_action_select,
	input  wire logic        pr_write,
	input  wire logic [5:0]  pr_num,
	input  wire logic        io_req,
	input  wire logic        io_local,
	input  wire logic        io_write,
	input  wire logic [31:0] io_addr,
	input  wire logic [3:0]  io_be,
	input  wire logic [31:0] io_wdata,
	output logic [31:0]      io_rdata,
	output logic             io_ack,
	output logic             io_err,
	output logic             hard_err_irq,
	input  wire logic        cyc_active,
	input  bel_cyc_t         cyc_kind,
	input  wire logic        bus_granted,
	input  wire logic        bus_reply,
	input  wire logic        demand_read_done,
	input  wire logic        bus_parity_err,
	input  wire logic [21:0] bus_addr,
	input  wire logic        mem_err,
	input  wire logic        mem_err_lmgh_read,
	input  wire logic        mem_err_lmgh_write,
	input  wire logic [28:0] mem_addr,
	output logic             retry_err,
	output logic             mem_write_irq
);
	bel_evt_if evt ();
	logic halt_s;
	logic pg_s;
	logic pg_q_reg;
	logic halt_q_reg;
	logic [31:0] status_reg;
	logic [31:0] status_next;
	logic [BEL_BUS_AW-1:0] bus_ea_reg;
	logic [BEL_BUS_AW-1:0] bus_ea_next;
	logic [BEL_MEM_AW-1:0] mem_ea_reg;
	logic [BEL_MEM_AW-1:0] mem_ea_next;
	logic [31:0] rdata_next;
	logic        ack_next;
	logic        err_next;
	logic        hard_next;
	logic        retry_next;
	logic        mwirq_next;
	logic        pg_fall;
	logic        halt_rise;
	logic        soft_rst;
	logic        acc;
	logic        st_hit;
	logic        bus_hit;
	logic        mem_hit;
	logic [31:0] clr;
	logic        par_evt;
	logic        mem_evt;
	logic        bus_cap;
	logic        pending;

	bel_sync u_halt (
		.core_clk (core_clk),
		.rst      (rst),
		.pin      (backplane_halt_line),
		.level    (halt_s)
	);
	bel_sync u_pg (
		.core_clk (core_clk),
		.rst      (rst),
		.pin      (dc_power_good),
		.level    (pg_s)
	);
	bel_timer #(.GRANT_CYC(GRANT_CYC)) u_timer (
		.core_clk    (core_clk),
		.rst         (rst),
		.cyc_active  (cyc_active),
		.cyc_kind    (cyc_kind),
		.bus_granted (bus_granted),
		.bus_reply   (bus_reply),
		.evt         (evt.timer)
	);

	// Event decode; only demand reads report parity
	always_comb begin
		pg_fall   = pg_q_reg && !pg_s;
		halt_rise = halt_s && !halt_q_reg;
		soft_rst  = pr_write && (pr_num == BEL_RESET_PR_NUM);
		par_evt   = demand_read_done && bus_parity_err && (cyc_kind == BEL_CYC_DEMAND);
		mem_evt   = mem_err;
		bus_cap   = par_evt || evt.nxm_pulse;
		pending   = status_reg[BEL_B_NXM] || status_reg[BEL_B_PAR] ||
		            status_reg[BEL_B_MEM] || status_reg[BEL_B_RSV0];
	end

	// Decode; external masters never reach the bank
	always_comb begin
		acc     = io_req && io_local;
		st_hit  = acc && (io_addr == BEL_STATUS_ADDR);
		bus_hit = acc && (io_addr == BEL_BUS_ADDR_ADDR);
		mem_hit = acc && (io_addr == BEL_MEM_ADDR_ADDR);
		clr     = '0;
		if (st_hit && io_write) begin
			for (int i = 0; i < 4; i++) begin
				if (io_be[i]) clr[i*8 +: 8] = io_wdata[i*8 +: 8];
			end
		end
	end

	// Status: set beats clear; mask keeps unused bits zero
	always_comb begin
		status_next = status_reg & ~clr;
		if (halt_rise && halt_line_enable) status_next[BEL_B_HALT] = 1'b1;
		if (pg_fall && pwr_action_select) status_next[BEL_B_PWR] = 1'b1;
		if (evt.nxm_pulse) status_next[BEL_B_NXM] = 1'b1;
		if (par_evt) status_next[BEL_B_PAR] = 1'b1;
		if (mem_evt) status_next[BEL_B_MEM] = 1'b1;
		if (evt.grant_pulse) status_next[BEL_B_GRANT] = 1'b1;
		if ((bus_cap || mem_evt) && pending) status_next[BEL_B_LOST] = 1'b1;
		status_next = status_next & BEL_STATUS_MASK;
		// Power-good loss and reset register clear every status flag
		if (soft_rst || pg_fall) status_next = BEL_STATUS_RST;
	end

	// Capture registers hold while an earlier capture stands
	always_comb begin
		bus_ea_next = bus_ea_reg;
		mem_ea_next = mem_ea_reg;
		if (bus_cap && !status_reg[BEL_B_PAR] && !status_reg[BEL_B_NXM])
			bus_ea_next = bus_addr[BEL_BUS_LSB +: BEL_BUS_AW];
		if (mem_evt && !status_reg[BEL_B_MEM])
			mem_ea_next = mem_addr[BEL_BUS_LSB +: BEL_MEM_AW];
	end

	// Read path and access answers
	always_comb begin
		rdata_next = '0;
		ack_next   = acc && (st_hit || bus_hit || mem_hit);
		err_next   = acc && !(st_hit || bus_hit || mem_hit);
		hard_next  = (bus_hit || mem_hit) && io_write;
		if ((bus_hit || mem_hit) && io_be != BEL_BE_LONG) begin
			ack_next = 1'b0;
			err_next = 1'b1;
		end
		if (st_hit && !io_write) rdata_next = status_reg & BEL_STATUS_MASK;
		if (bus_hit && !io_write) rdata_next = {19'h0, bus_ea_reg};
		if (mem_hit && !io_write) rdata_next = {12'h0, mem_ea_reg};
		retry_next = mem_evt && mem_err_lmgh_read;
		mwirq_next = mem_evt && mem_err_lmgh_write;
	end

	// Capture registers have no reset value; the rest clear
	always_ff @(posedge core_clk) begin
		bus_ea_reg <= bus_ea_next;
		mem_ea_reg <= mem_ea_next;
		if (rst) begin
			status_reg    <= BEL_STATUS_RST;
			pg_q_reg      <= 1'b0;
			halt_q_reg    <= 1'b0;
			io_rdata      <= '0;
			io_ack        <= 1'b0;
			io_err        <= 1'b0;
			hard_err_irq  <= 1'b0;
			retry_err     <= 1'b0;
			mem_write_irq <= 1'b0;
		end else begin
			status_reg    <= status_next;
			pg_q_reg      <= pg_s;
			halt_q_reg    <= halt_s;
			io_rdata      <= rdata_next;
			io_ack        <= ack_next;
			io_err        <= err_next;
			hard_err_irq  <= hard_next;
			retry_err     <= retry_next;
			mem_write_irq <= mwirq_next;
		end
	end

	// Checks

	// Unused status bits never set
	a_status_zero: assert property (@(posedge core_clk) disable iff (rst)
		(status_reg & ~BEL_STATUS_MASK) == '0)
		else $error("unused status bit set");
	// Status reads show only defined flags
	a_status_read: assert property (@(posedge core_clk) disable iff (rst)
		st_hit && !io_write |=> (io_rdata & ~BEL_STATUS_MASK) == '0)
		else $error("unused status bit read");
	// Write one clears a flag
	a_w1c_clear: assert property (@(posedge core_clk) disable iff (rst)
		st_hit && io_write && io_be[0] && io_wdata[BEL_B_PAR] && !par_evt && !soft_rst
		|=> !status_reg[BEL_B_PAR])
		else $error("write one did not clear");
	// Flag holds without a clear
	a_sticky_hold: assert property (@(posedge core_clk) disable iff (rst)
		status_reg[BEL_B_MEM] && !clr[BEL_B_MEM] && !soft_rst && !pg_fall
		|=> status_reg[BEL_B_MEM])
		else $error("flag dropped");
	// Reset register empties the log
	a_soft_reset: assert property (@(posedge core_clk) disable iff (rst)
		soft_rst |=> status_reg == '0)
		else $error("reset register ignored");
	// Power-good loss empties the log
	a_pg_clear: assert property (@(posedge core_clk) disable iff (rst)
		pg_fall |=> status_reg == '0)
		else $error("power-good loss ignored");
	// Enabled halt edge logs
	a_halt_sets: assert property (@(posedge core_clk) disable iff (rst)
		halt_rise && halt_line_enable && !soft_rst && !pg_fall |=> status_reg[BEL_B_HALT])
		else $error("no halt flag");
	// Halt flag needs an enabled halt edge
	a_halt_gated: assert property (@(posedge core_clk) disable iff (rst)
		!status_reg[BEL_B_HALT] && !(halt_rise && halt_line_enable) |=> !status_reg[BEL_B_HALT])
		else $error("halt flag without enabled halt");
	// Reply timeout logs
	a_nxm_sets: assert property (@(posedge core_clk) disable iff (rst)
		evt.nxm_pulse && !soft_rst && !pg_fall |=> status_reg[BEL_B_NXM])
		else $error("no nxm flag");
	// Reply flag comes only from the watchdog
	a_nxm_only: assert property (@(posedge core_clk) disable iff (rst)
		!status_reg[BEL_B_NXM] && !evt.nxm_pulse |=> !status_reg[BEL_B_NXM])
		else $error("nxm flag without timeout");
	// Grant timeout logs
	a_grant_sets: assert property (@(posedge core_clk) disable iff (rst)
		evt.grant_pulse && !soft_rst && !pg_fall |=> status_reg[BEL_B_GRANT])
		else $error("no grant flag");
	// Only demand cycles raise bus errors
	a_demand_only: assert property (@(posedge core_clk) disable iff (rst)
		cyc_kind != BEL_CYC_DEMAND |-> !evt.nxm_pulse && !evt.grant_pulse && !par_evt)
		else $error("non-demand cycle flagged");
	// Parity error logs
	a_par_sets: assert property (@(posedge core_clk) disable iff (rst)
		par_evt && !soft_rst && !pg_fall |=> status_reg[BEL_B_PAR])
		else $error("no parity flag");
	// Memory error logs
	a_mem_sets: assert property (@(posedge core_clk) disable iff (rst)
		mem_evt && !soft_rst && !pg_fall |=> status_reg[BEL_B_MEM])
		else $error("no memory flag");
	// Memory error over a standing flag is lost
	a_lost_sets: assert property (@(posedge core_clk) disable iff (rst)
		mem_evt && pending && !soft_rst && !pg_fall |=> status_reg[BEL_B_LOST])
		else $error("lost not set");
	// Bus error over a standing flag is lost
	a_lost_bus: assert property (@(posedge core_clk) disable iff (rst)
		bus_cap && pending && !soft_rst && !pg_fall |=> status_reg[BEL_B_LOST])
		else $error("lost not set for bus error");
	// Bus address holds while a bus flag stands
	a_bus_hold: assert property (@(posedge core_clk) disable iff (rst)
		(status_reg[BEL_B_PAR] || status_reg[BEL_B_NXM]) |=> $stable(bus_ea_reg))
		else $error("bus address changed");
	// Bus address upper bits read zero
	a_bus_zero: assert property (@(posedge core_clk) disable iff (rst)
		bus_hit && !io_write |=> io_rdata[31:BEL_BUS_AW] == '0)
		else $error("bus address upper bits set");
	// Memory address holds while its flag stands
	a_mem_hold: assert property (@(posedge core_clk) disable iff (rst)
		status_reg[BEL_B_MEM] |=> $stable(mem_ea_reg))
		else $error("memory address changed");
	// Memory address upper bits read zero
	a_mem_zero: assert property (@(posedge core_clk) disable iff (rst)
		mem_hit && !io_write |=> io_rdata[31:BEL_MEM_AW] == '0)
		else $error("memory address upper bits set");
	// Address register writes raise hard error
	a_ro_hard: assert property (@(posedge core_clk) disable iff (rst)
		(bus_hit || mem_hit) && io_write |=> hard_err_irq)
		else $error("no hard error");
	// Memory address write raises hard error
	a_mem_ro: assert property (@(posedge core_clk) disable iff (rst)
		mem_hit && io_write |=> hard_err_irq)
		else $error("no hard error on memory address write");
	// Remote accesses get no answer
	a_remote_quiet: assert property (@(posedge core_clk) disable iff (rst)
		io_req && !io_local |=> !io_ack && !io_err)
		else $error("remote access answered");
	// Short address register access refused
	a_long_only: assert property (@(posedge core_clk) disable iff (rst)
		(bus_hit || mem_hit) && io_be != BEL_BE_LONG |=> io_err && !io_ack)
		else $error("short address access accepted");
	// Ack and error never together
	a_ack_excl: assert property (@(posedge core_clk) disable iff (rst)
		io_ack |-> !io_err)
		else $error("ack and error together");
	// Local-miss read reports on retry
	a_retry_read: assert property (@(posedge core_clk) disable iff (rst)
		mem_evt && mem_err_lmgh_read |=> retry_err)
		else $error("no retry error");
	// Local-miss write interrupts
	a_write_irq: assert property (@(posedge core_clk) disable iff (rst)
		mem_evt && mem_err_lmgh_write |=> mem_write_irq)
		else $error("no write interrupt");

	// Main scenarios reached
	c_nxm: cover property (@(posedge core_clk) evt.nxm_pulse);
	c_grant: cover property (@(posedge core_clk) evt.grant_pulse);
	c_lost: cover property (@(posedge core_clk) status_reg[BEL_B_LOST]);
	c_clear: cover property (@(posedge core_clk) st_hit && io_write);
	c_mem: cover property (@(posedge core_clk) mem_evt);
endmodule

// file: bel_pkg.sv
// Constants and types for the backplane bus error log register bank
package bel_pkg;
	localparam logic [31:0] BEL_STATUS_ADDR   = 32'h20080004;
	localparam logic [31:0] BEL_BUS_ADDR_ADDR = 32'h20080008;
	localparam logic [31:0] BEL_MEM_ADDR_ADDR = 32'h2008000C;
	localparam logic [5:0]  BEL_RESET_PR_NUM  = 6'h37;
	// Status bit positions
	localparam int BEL_B_HALT  = 15;
	localparam int BEL_B_PWR   = 14;
	localparam int BEL_B_NXM   = 7;
	localparam int BEL_B_PAR   = 5;
	localparam int BEL_B_MEM   = 4;
	localparam int BEL_B_LOST  = 3;
	localparam int BEL_B_GRANT = 2;
	localparam int BEL_B_RSV0  = 0;
	localparam logic [31:0] BEL_STATUS_MASK = 32'h0000C0BC;
	localparam logic [31:0] BEL_STATUS_RST  = 32'h00000000;
	localparam logic [3:0]  BEL_BE_LONG     = 4'hF;
	localparam int BEL_BUS_AW = 13;
	localparam int BEL_MEM_AW = 20;
	localparam int BEL_BUS_LSB = 9;
	// Timeouts
	localparam int BEL_CLK_NS       = 10;
	localparam int BEL_NXM_US       = 10;
	localparam int BEL_GRANT_MS     = 10;
	localparam int BEL_NXM_CYC      = BEL_NXM_US * 1000 / BEL_CLK_NS;
	localparam int BEL_GRANT_CYC    = BEL_GRANT_MS * 1000000 / BEL_CLK_NS;
	localparam int BEL_CNT_W        = 20;
	// Kind of backplane cycle in flight
	typedef enum logic [2:0] {
		BEL_CYC_DEMAND   = 3'b001,
		BEL_CYC_PREFETCH = 3'b010,
		BEL_CYC_INTACK   = 3'b100
	} bel_cyc_t;
endpackage

// file: bel_evt_if.sv
`timescale 1ns/1ns
// Error events passed from the bus timer to the register bank
interface bel_evt_if;
	logic nxm_pulse;
	logic grant_pulse;
	modport timer (output nxm_pulse, output grant_pulse);
	modport bank  (input nxm_pulse, input grant_pulse);
endinterface

// file: bel_sync.sv
`timescale 1ns/1ns
// Two-flop synchroniser for one pin level
module bel_sync (
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic pin,
	output logic      level
);
	logic s1_reg;
	logic s1_next;
	logic s2_next;
	// Second flop is the only reader of the first
	always_comb begin
		s1_next = pin;
		s2_next = s1_reg;
	end
	always_ff @(posedge core_clk) begin
		if (rst) begin
			s1_reg <= 1'b0;
			level  <= 1'b0;
		end else begin
			s1_reg <= s1_next;
			level  <= s2_next;
		end
	end
endmodule

// file: bel_timer.sv
`timescale 1ns/1ns
// Reply and grant watchdogs for processor demand cycles
module bel_timer
	import bel_pkg::*;
#(
	parameter int GRANT_CYC = BEL_GRANT_CYC
) (
	input  wire logic     core_clk,
	input  wire logic     rst,
	input  wire logic     cyc_active,
	input  bel_cyc_t      cyc_kind,
	input  wire logic     bus_granted,
	input  wire logic     bus_reply,
	bel_evt_if.timer      evt
);
	logic [BEL_CNT_W-1:0] cnt_reg;
	logic [BEL_CNT_W-1:0] cnt_next;
	logic                 fired_reg;
	logic                 fired_next;
	logic                 demand;
	logic                 granted_q_reg;
	// Only demand cycles may time out; others abort silently
	always_comb begin
		demand          = cyc_active && (cyc_kind == BEL_CYC_DEMAND);
		cnt_next        = cnt_reg;
		fired_next      = fired_reg;
		evt.nxm_pulse   = 1'b0;
		evt.grant_pulse = 1'b0;
		if (!demand || bus_reply) begin
			cnt_next   = '0;
			fired_next = 1'b0;
		end else if (!fired_reg) begin
			cnt_next = cnt_reg + 1'b1;
			if (!bus_granted && cnt_reg == BEL_CNT_W'(GRANT_CYC - 1)) begin
				evt.grant_pulse = 1'b1;
				fired_next      = 1'b1;
			end else if (bus_granted && cnt_reg == BEL_CNT_W'(BEL_NXM_CYC - 1)) begin
				evt.nxm_pulse = 1'b1;
				fired_next    = 1'b1;
			end
		end
		// Grant restarts the count for the reply timer
		if (demand && bus_granted && !granted_q_reg) cnt_next = '0;
	end
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cnt_reg       <= '0;
			fired_reg     <= 1'b0;
			granted_q_reg <= 1'b0;
		end else begin
			cnt_reg       <= cnt_next;
			fired_reg     <= fired_next;
			granted_q_reg <= bus_granted;
		end
	end
endmodule

// file: bel_cpu_model.sv
// Local processor model issuing register accesses
`timescale 1ns/1ns
module bel_cpu_model (
	input  wire logic        core_clk,
	output logic             io_req,
	output logic             io_local,
	output logic             io_write,
	output logic [31:0]      io_addr,
	output logic [3:0]       io_be,
	output logic [31:0]      io_wdata,
	input  wire logic [31:0] io_rdata,
	input  wire logic        io_ack,
	input  wire logic        io_err,
	input  wire logic        hard_err_irq
);
	logic        is_local = 1'b1;
	logic [31:0] last_q;
	logic        last_ack;
	logic        last_err;
	logic        last_irq;
	assign io_local = is_local;
	initial begin
		io_req = 1'b0;
		io_write = 1'b0;
		io_addr = 32'h0;
		io_be = 4'h0;
		io_wdata = 32'h0;
	end
	// Request held over one edge; address and data then show inverted junk, not stale data
	task automatic acc(input logic w, input logic [31:0] a, input logic [3:0] be, input logic [31:0] d);
		logic got;
		@(negedge core_clk);
		io_req = 1'b1;
		io_write = w;
		io_addr = a;
		io_be = be;
		io_wdata = d;
		@(negedge core_clk);
		io_req = 1'b0;
		io_addr = ~a;
		io_wdata = ~d;
		got = 1'b0;
		last_ack = 1'b0;
		last_err = 1'b0;
		last_irq = 1'b0;
		last_q = 32'h0;
		// Answer window of three cycles; no answer means refused
		repeat (3) begin
			if (!got && (io_ack === 1'b1 || io_err === 1'b1)) begin
				got = 1'b1;
				last_ack = io_ack;
				last_err = io_err;
				last_q = io_rdata;
			end
			last_irq |= (hard_err_irq === 1'b1);
			@(negedge core_clk);
		end
	endtask
endmodule

// file: bel_bank_bench.sv
// Self-checking bench for the error log register bank
`timescale 1ns/1ns
module bel_bank_bench;
	import bel_pkg::*;
	logic core_clk = 1'b0, rst = 1'b1, dc_power_good = 1'b1, backplane_halt_line = 1'b0;
	logic halt_line_enable = 1'b0, pwr_action_select = 1'b0, pr_write = 1'b0, cyc_active = 1'b0;
	logic bus_granted = 1'b0, bus_reply = 1'b0, demand_read_done = 1'b0, bus_parity_err = 1'b0;
	logic mem_err = 1'b0, mem_err_lmgh_read = 1'b0, mem_err_lmgh_write = 1'b0;
	logic io_req, io_local, io_write, io_ack, io_err, hard_err_irq, retry_err, mem_write_irq;
	logic [5:0]  pr_num = 6'h00;
	logic [21:0] bus_addr = 22'h0;
	logic [28:0] mem_addr = 29'h0;
	logic [31:0] io_addr, io_wdata, io_rdata;
	logic [3:0]  io_be;
	bel_cyc_t    cyc_kind = BEL_CYC_DEMAND;
	int          n_mismatch = 0, n_compared = 0;
	logic        seen_r, seen_w;
	// Grant watchdog shortened so the no-grant case fits the run
	bel_bank #(.GRANT_CYC(50)) dut_u (.core_clk(core_clk), .rst(rst), .dc_power_good(dc_power_good),
		.backplane_halt_line(backplane_halt_line), .halt_line_enable(halt_line_enable),
		.pwr_action_select(pwr_action_select), .pr_write(pr_write), .pr_num(pr_num), .io_req(io_req),
		.io_local(io_local), .io_write(io_write), .io_addr(io_addr), .io_be(io_be), .io_wdata(io_wdata),
		.io_rdata(io_rdata), .io_ack(io_ack), .io_err(io_err), .hard_err_irq(hard_err_irq),
		.cyc_active(cyc_active), .cyc_kind(cyc_kind), .bus_granted(bus_granted), .bus_reply(bus_reply),
		.demand_read_done(demand_read_done), .bus_parity_err(bus_parity_err), .bus_addr(bus_addr),
		.mem_err(mem_err), .mem_err_lmgh_read(mem_err_lmgh_read), .mem_err_lmgh_write(mem_err_lmgh_write),
		.mem_addr(mem_addr), .retry_err(retry_err), .mem_write_irq(mem_write_irq));
	bel_cpu_model cpu_u (.core_clk(core_clk), .io_req(io_req), .io_local(io_local), .io_write(io_write),
		.io_addr(io_addr), .io_be(io_be), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_ack(io_ack),
		.io_err(io_err), .hard_err_irq(hard_err_irq));
	always #5 core_clk = ~core_clk;
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic rd(input string name, input logic [31:0] a, input logic [31:0] exp);
		cpu_u.acc(1'b0, a, BEL_BE_LONG, 32'h0);
		chk(name, cpu_u.last_q, exp);
		chk("read_ack", {31'h0, cpu_u.last_ack}, 32'h1);
	endtask
	task automatic wr(input logic [31:0] a, input logic [3:0] be, input logic [31:0] d);
		cpu_u.acc(1'b1, a, be, d);
	endtask
	// Access rules: reset value, refusals, read-only address registers
	task automatic t_access();
		rd("status_rst", BEL_STATUS_ADDR, 32'h0);
		cpu_u.is_local = 1'b0;
		cpu_u.acc(1'b0, BEL_STATUS_ADDR, BEL_BE_LONG, 32'h0);
		chk("remote_ack", {31'h0, cpu_u.last_ack}, 32'h0);
		chk("remote_err", {31'h0, cpu_u.last_err}, 32'h0);
		cpu_u.is_local = 1'b1;
		cpu_u.acc(1'b0, BEL_BUS_ADDR_ADDR, 4'h3, 32'h0);
		chk("word_addr_err", cpu_u.last_err, 1'b1);
		wr(BEL_BUS_ADDR_ADDR, BEL_BE_LONG, 32'h0);
		chk("bus_wr_irq", cpu_u.last_irq, 1'b1);
		wr(BEL_MEM_ADDR_ADDR, BEL_BE_LONG, 32'h0);
		chk("mem_wr_irq", cpu_u.last_irq, 1'b1);
	endtask
	// Halt flag: enable gating, stickiness, lane-wise clear
	task automatic t_halt();
		backplane_halt_line = 1'b1;
		tick(6);
		rd("halt_off", BEL_STATUS_ADDR, 32'h0);
		backplane_halt_line = 1'b0;
		halt_line_enable = 1'b1;
		tick(4);
		backplane_halt_line = 1'b1;
		tick(6);
		backplane_halt_line = 1'b0;
		tick(4);
		rd("halt_set", BEL_STATUS_ADDR, 32'h8000);
		wr(BEL_STATUS_ADDR, BEL_BE_LONG, 32'h0);
		rd("w0_keeps", BEL_STATUS_ADDR, 32'h8000);
		wr(BEL_STATUS_ADDR, 4'h1, 32'h80BC);
		rd("lane_keeps", BEL_STATUS_ADDR, 32'h8000);
		wr(BEL_STATUS_ADDR, 4'h2, 32'h8000);
		rd("w1_clears", BEL_STATUS_ADDR, 32'h0);
	endtask
	task automatic par(input logic pe, input logic [21:0] a);
		@(negedge core_clk);
		demand_read_done = 1'b1;
		bus_parity_err = pe;
		bus_addr = a;
		@(negedge core_clk);
		demand_read_done = 1'b0;
		bus_parity_err = 1'b0;
		bus_addr = ~a;
		tick(2);
	endtask
	// Parity capture, then a second error is lost and the address holds
	task automatic t_parity();
		par(1'b0, 22'h155400);
		rd("clean_read", BEL_STATUS_ADDR, 32'h0);
		par(1'b1, 22'h3FFE00);
		rd("par_set", BEL_STATUS_ADDR, 32'h20);
		rd("bus_page", BEL_BUS_ADDR_ADDR, 32'h1FFF);
		par(1'b1, 22'h000200);
		rd("lost_set", BEL_STATUS_ADDR, 32'h28);
		rd("bus_held", BEL_BUS_ADDR_ADDR, 32'h1FFF);
		wr(BEL_STATUS_ADDR, BEL_BE_LONG, 32'h28);
	endtask
	task automatic merr(input logic [28:0] a, input logic r, input logic w);
		@(negedge core_clk);
		mem_err = 1'b1;
		mem_addr = a;
		mem_err_lmgh_read = r;
		mem_err_lmgh_write = w;
		seen_r = 1'b0;
		seen_w = 1'b0;
		repeat (3) begin
			@(negedge core_clk);
			mem_err = 1'b0;
			mem_addr = ~a;
			seen_r |= (retry_err === 1'b1);
			seen_w |= (mem_write_irq === 1'b1);
		end
		mem_err_lmgh_read = 1'b0;
		mem_err_lmgh_write = 1'b0;
	endtask
	// Memory error capture, hold until cleared, retry and write reports
	task automatic t_mem();
		merr(29'h1FFFFE00, 1'b1, 1'b0);
		chk("retry", {seen_r, seen_w}, 2'b10);
		rd("mem_set", BEL_STATUS_ADDR, 32'h10);
		rd("mem_page", BEL_MEM_ADDR_ADDR, 32'hFFFFF);
		merr(29'h00000200, 1'b0, 1'b1);
		chk("wr_irq", {seen_r, seen_w}, 2'b01);
		rd("mem_lost", BEL_STATUS_ADDR, 32'h18);
		rd("mem_held", BEL_MEM_ADDR_ADDR, 32'hFFFFF);
		wr(BEL_STATUS_ADDR, 4'h1, 32'h18);
	endtask
	task automatic cyc(input bel_cyc_t k, input logic g, input int n);
		@(negedge core_clk);
		cyc_kind = k;
		bus_granted = g;
		cyc_active = 1'b1;
		tick(n);
		cyc_active = 1'b0;
		bus_granted = 1'b0;
		tick(3);
	endtask
	// Reply and grant watchdogs: only demand cycles may log
	task automatic t_timers();
		cyc(BEL_CYC_PREFETCH, 1'b1, 1020);
		cyc(BEL_CYC_INTACK, 1'b0, 70);
		rd("no_log", BEL_STATUS_ADDR, 32'h0);
		cyc(BEL_CYC_DEMAND, 1'b1, 1020);
		rd("nxm_set", BEL_STATUS_ADDR, 32'h80);
		wr(BEL_STATUS_ADDR, BEL_BE_LONG, 32'h80);
		cyc(BEL_CYC_DEMAND, 1'b0, 70);
		rd("grant_set", BEL_STATUS_ADDR, 32'h4);
	endtask
	// Reset register write and power-good loss clear the log
	task automatic t_clear();
		@(negedge core_clk);
		pr_write = 1'b1;
		pr_num = 6'h36;
		@(negedge core_clk);
		pr_write = 1'b0;
		tick(2);
		rd("pr_other", BEL_STATUS_ADDR, 32'h4);
		@(negedge core_clk);
		pr_write = 1'b1;
		pr_num = BEL_RESET_PR_NUM;
		@(negedge core_clk);
		pr_write = 1'b0;
		tick(2);
		rd("pr_clear", BEL_STATUS_ADDR, 32'h0);
		backplane_halt_line = 1'b1;
		tick(6);
		rd("halt_again", BEL_STATUS_ADDR, 32'h8000);
		pwr_action_select = 1'b1;
		dc_power_good = 1'b0;
		tick(6);
		rd("pg_clear", BEL_STATUS_ADDR, 32'h0);
		dc_power_good = 1'b1;
	endtask
	task automatic report_and_stop();
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Whole run is about 2400 cycles; hang cut at 20000
	initial begin
		repeat (20000) @(posedge core_clk);
		n_mismatch++;
		report_and_stop();
	end
	initial begin
		repeat (12) @(negedge core_clk);
		rst = 1'b0;
		t_access();
		t_halt();
		t_parity();
		t_mem();
		t_timers();
		t_clear();
		report_and_stop();
	end
endmodule
